// ===== design/sssb_pkg.sv
// constants for the supply safety status bank
// assumes an 8-bit status read port and one system clock
package sssb_pkg;
  localparam int unsigned REG_W         = 8;
  localparam int unsigned SEL_W         = 2;
  // register select codes
  localparam logic [1:0]  SEL_RAIL      = 2'h0;
  localparam logic [1:0]  SEL_FAULT     = 2'h1;
  localparam logic [1:0]  SEL_CRCWD     = 2'h2;
  // rail voltage status bit positions
  localparam int unsigned B_PRE_OV      = 7;
  localparam int unsigned B_PRE_UV      = 6;
  localparam int unsigned B_XCV_OV      = 5;
  localparam int unsigned B_XCV_UV      = 4;
  localparam int unsigned B_IO_OV       = 3;
  localparam int unsigned B_IO_UV       = 2;
  localparam int unsigned B_CORE_OV     = 1;
  localparam int unsigned B_CORE_UV     = 0;
  // regulator fault status bit positions
  localparam int unsigned B_XCV_ILIM    = 7;
  localparam int unsigned B_IO_ILIM     = 6;
  localparam int unsigned B_SNS_UV      = 5;
  localparam int unsigned B_SNS_OV      = 4;
  localparam int unsigned B_SNS_OT      = 2;
  localparam int unsigned B_XCV_OT      = 1;
  localparam int unsigned B_IO_OT       = 0;
  // crc / watchdog status bit positions
  localparam int unsigned B_CFG_CRC     = 5;
  localparam int unsigned B_NVM_CRC     = 4;
  localparam int unsigned CNT_W         = 3;
  localparam logic [2:0]  WD_CNT_INIT   = 3'h5;
  localparam logic [2:0]  WD_CNT_MAX    = 3'h7;
  localparam logic [2:0]  WD_CNT_MIN    = 3'h0;
  localparam logic [2:0]  WD_CNT_STEP   = 3'h1;
  localparam logic [7:0]  RESET_VAL     = 8'h00;
  localparam logic        OT_MASK_RST   = 1'b1;
endpackage

// ===== design/sssb_wd_counter.sv
// watchdog failure counter with saturation and fail detection
// assumes event pulses are one cycle wide and synchronous
`timescale 1ns/100ps
module sssb_wd_counter (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_reinit,
  input  wire logic                   i_reload,
  input  wire logic                   i_wd_bad,
  input  wire logic                   i_wd_good,
  input  wire logic                   i_watchdog_reset_enable,
  output logic [sssb_pkg::CNT_W-1:0]  o_count,
  output logic                        o_fail
);
  import sssb_pkg::*;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             fail_r;
  logic             fail_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    fail_nxt = 1'b0;
    if (i_reinit || i_reload) begin
      cnt_nxt = WD_CNT_INIT;
    end else if (i_wd_bad) begin
      if (cnt_r == WD_CNT_MAX) begin
        fail_nxt = i_watchdog_reset_enable;
      end else begin
        cnt_nxt = cnt_r + WD_CNT_STEP;
      end
    end else if (i_wd_good && cnt_r != WD_CNT_MIN) begin
      cnt_nxt = cnt_r - WD_CNT_STEP;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r  <= WD_CNT_INIT;
      fail_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      fail_r <= fail_nxt;
    end
  end

  assign o_count = cnt_r;
  assign o_fail  = fail_r;

  AST_SAT_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (cnt_r == WD_CNT_MAX && i_wd_bad && !i_reinit && !i_reload) |=> cnt_r == WD_CNT_MAX)
    else $error("counter wrapped above seven");
  AST_FAIL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (cnt_r == WD_CNT_MAX && i_wd_bad && i_watchdog_reset_enable && !i_reinit && !i_reload) |=> o_fail)
    else $error("watchdog failure not flagged");
  AST_RELOAD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_reload |=> cnt_r == WD_CNT_INIT)
    else $error("counter not reloaded to five");
endmodule

// ===== design/sssb_status_bank.sv
// read-only safety status bank: rail, regulator fault and crc/watchdog status
// assumes monitor inputs are synchronous levels, events one-cycle pulses
`timescale 1ns/100ps
module sssb_status_bank (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_logic_self_test_done,
  // live monitor conditions
  input  wire logic                        i_prereg_ov,
  input  wire logic                        i_prereg_uv,
  input  wire logic                        i_xcv_ov,
  input  wire logic                        i_xcv_uv,
  input  wire logic                        i_io_ov,
  input  wire logic                        i_io_uv,
  input  wire logic                        i_core_ov,
  input  wire logic                        i_core_uv,
  input  wire logic                        i_xcv_ilim,
  input  wire logic                        i_io_ilim,
  input  wire logic                        i_sns_uv,
  input  wire logic                        i_sns_ov,
  input  wire logic                        i_sns_ot,
  input  wire logic                        i_xcv_ot,
  input  wire logic                        i_io_ot,
  // crc check results
  input  wire logic                        i_cfg_crc_valid,
  input  wire logic [sssb_pkg::REG_W-1:0]  i_cfg_crc_calc,
  input  wire logic [sssb_pkg::REG_W-1:0]  i_cfg_crc_expect,
  input  wire logic                        i_nvm_crc_done,
  input  wire logic                        i_nvm_crc_mismatch,
  // device state and watchdog events
  input  wire logic                        i_in_diag,
  input  wire logic                        i_enter_diag_active,
  input  wire logic                        i_wd_bad,
  input  wire logic                        i_wd_good,
  input  wire logic                        i_watchdog_reset_enable,
  // control written by the host elsewhere
  input  wire logic                        i_xcv_en_set,
  input  wire logic                        i_xcv_en_clr,
  input  wire logic                        i_ot_mask_wr,
  input  wire logic                        i_ot_mask_val,
  input  wire logic                        i_enable_drive_output_req,
  // register read port
  input  wire logic [sssb_pkg::SEL_W-1:0]  i_rd_sel,
  output logic [sssb_pkg::REG_W-1:0]       o_rd_data,
  // side effects
  output logic                             o_xcv_en,
  output logic                             o_xcv_reg_disable,
  output logic                             o_sns_reg_disable,
  output logic                             o_io_reg_disable,
  output logic                             o_reset_req,
  output logic                             o_safe_req,
  output logic                             o_enable_drive_output,
  output logic                             o_watchdog_failure_flag
);
  import sssb_pkg::*;
  logic [REG_W-1:0] rail_r;
  logic [REG_W-1:0] rail_nxt;
  logic [REG_W-1:0] fault_r;
  logic [REG_W-1:0] fault_nxt;
  logic             cfg_err_r;
  logic             cfg_err_nxt;
  logic             nvm_err_r;
  logic             nvm_err_nxt;
  logic             xcv_en_r;
  logic             xcv_en_nxt;
  logic             ot_mask_r;
  logic             ot_mask_nxt;
  logic             enable_drive_output_r;
  logic             enable_drive_output_nxt;
  logic [REG_W-1:0] rd_r;
  logic [REG_W-1:0] rd_nxt;
  logic [CNT_W-1:0] wd_cnt;
  logic             xcv_shutdown;
  logic [REG_W-1:0] crcwd_view;

  sssb_wd_counter u_wdc (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_reinit    (i_logic_self_test_done),
    .i_reload    (i_enter_diag_active),
    .i_wd_bad    (i_wd_bad),
    .i_wd_good   (i_wd_good),
    .i_watchdog_reset_enable (i_watchdog_reset_enable),
    .o_count     (wd_cnt),
    .o_fail      (o_watchdog_failure_flag)
  );

  assign xcv_shutdown = i_xcv_ot && ot_mask_r;

  always_comb begin
    rail_nxt = RESET_VAL;
    rail_nxt[B_PRE_OV]  = i_prereg_ov;
    rail_nxt[B_PRE_UV]  = i_prereg_uv;
    rail_nxt[B_XCV_OV]  = i_xcv_ov;
    rail_nxt[B_XCV_UV]  = i_xcv_uv;
    rail_nxt[B_IO_OV]   = i_io_ov;
    rail_nxt[B_IO_UV]   = i_io_uv;
    rail_nxt[B_CORE_OV] = i_core_ov;
    rail_nxt[B_CORE_UV] = i_core_uv;
  end

  always_comb begin
    fault_nxt = RESET_VAL;
    fault_nxt[B_XCV_ILIM] = i_xcv_ilim || !xcv_en_r;
    fault_nxt[B_IO_ILIM]  = i_io_ilim;
    fault_nxt[B_SNS_UV]   = i_sns_uv;
    fault_nxt[B_SNS_OV]   = i_sns_ov;
    fault_nxt[B_SNS_OT]   = i_sns_ot;
    fault_nxt[B_XCV_OT]   = i_xcv_ot;
    fault_nxt[B_IO_OT]    = i_io_ot;
  end

  always_comb begin
    cfg_err_nxt = cfg_err_r;
    nvm_err_nxt = nvm_err_r;
    if (i_cfg_crc_valid) begin
      cfg_err_nxt = (i_cfg_crc_calc != i_cfg_crc_expect);
    end
    if (i_nvm_crc_done) begin
      nvm_err_nxt = i_nvm_crc_mismatch;
      if (!i_nvm_crc_mismatch) begin
        cfg_err_nxt = 1'b0;
      end
    end
    if (i_logic_self_test_done) begin
      cfg_err_nxt = 1'b0;
      nvm_err_nxt = 1'b0;
    end
  end

  always_comb begin
    ot_mask_nxt = i_ot_mask_wr ? i_ot_mask_val : ot_mask_r;
    xcv_en_nxt  = xcv_en_r;
    if (i_xcv_en_set) begin
      xcv_en_nxt = 1'b1;
    end
    if (i_xcv_en_clr) begin
      xcv_en_nxt = 1'b0;
    end
    if (xcv_shutdown) begin
      xcv_en_nxt = 1'b0;
    end
  end

  always_comb begin
    enable_drive_output_nxt = i_enable_drive_output_req && (wd_cnt < WD_CNT_INIT);
  end

  always_comb begin
    crcwd_view = RESET_VAL;
    crcwd_view[B_CFG_CRC] = cfg_err_r;
    crcwd_view[B_NVM_CRC] = nvm_err_r;
    crcwd_view[CNT_W-1:0] = wd_cnt;
    case (i_rd_sel)
      SEL_RAIL:  rd_nxt = rail_r;
      SEL_FAULT: rd_nxt = fault_r;
      SEL_CRCWD: rd_nxt = crcwd_view;
      default:   rd_nxt = RESET_VAL;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rail_r    <= RESET_VAL;
      fault_r   <= RESET_VAL;
      cfg_err_r <= 1'b0;
      nvm_err_r <= 1'b0;
      xcv_en_r  <= 1'b0;
      ot_mask_r <= OT_MASK_RST;
      rd_r      <= RESET_VAL;
      enable_drive_output_r   <= 1'b0;
    end else begin
      rail_r    <= rail_nxt;
      fault_r   <= fault_nxt;
      cfg_err_r <= cfg_err_nxt;
      nvm_err_r <= nvm_err_nxt;
      xcv_en_r  <= xcv_en_nxt;
      ot_mask_r <= ot_mask_nxt;
      rd_r      <= rd_nxt;
      enable_drive_output_r   <= enable_drive_output_nxt;
    end
  end

  assign o_rd_data         = rd_r;
  assign o_xcv_en          = xcv_en_r;
  assign o_sns_reg_disable = fault_r[B_SNS_OT];
  assign o_io_reg_disable  = fault_r[B_IO_OT];
  assign o_xcv_reg_disable = !xcv_en_r;
  assign o_reset_req       = xcv_shutdown;
  assign o_safe_req        = nvm_err_r && i_in_diag;
  assign o_enable_drive_output           = enable_drive_output_r;

  sequence s_xcv_ot_masked;
    i_xcv_ot && ot_mask_r;
  endsequence
  sequence s_en_cleared;
    !xcv_en_r ##0 o_xcv_reg_disable;
  endsequence

  AST_OT_SHUTDOWN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_xcv_ot_masked |=> s_en_cleared)
    else $error("masked overtemp did not shut down transceiver rail");
  AST_OT_NOACT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_xcv_ot && !ot_mask_r && xcv_en_r && !i_xcv_en_clr && !i_ot_mask_wr) |=> xcv_en_r)
    else $error("unmasked overtemp changed enable");
  AST_ILIM_DIS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !xcv_en_r |=> fault_r[B_XCV_ILIM])
    else $error("current limit flag low while rail disabled");
  AST_RAIL_LIVE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> rail_r[B_IO_OV] == $past(i_io_ov))
    else $error("io overvoltage flag not live");
  AST_CORE_LIVE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> rail_r[B_CORE_UV] == $past(i_core_uv))
    else $error("core undervoltage flag not live");
  AST_PRE_LIVE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> rail_r[B_PRE_OV] == $past(i_prereg_ov))
    else $error("pre-regulator flag not live");
  AST_RSV_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_rd_sel == SEL_CRCWD) |=> o_rd_data[7:6] == 2'h0 && o_rd_data[3] == 1'b0)
    else $error("reserved bits not zero");
  AST_NVM_CLR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_nvm_crc_done && !i_nvm_crc_mismatch) |=> !cfg_err_r)
    else $error("clean nvm check left config error set");
  AST_CFG_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cfg_crc_valid && i_cfg_crc_calc != i_cfg_crc_expect && !i_nvm_crc_done
     && !i_logic_self_test_done) |=> cfg_err_r)
    else $error("config crc mismatch not flagged");
  AST_ENABLE_DRIVE_OUTPUT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wd_cnt >= WD_CNT_INIT) |=> !o_enable_drive_output)
    else $error("enable drive with counter at or above five");
  AST_SAFE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_nvm_crc_done && i_nvm_crc_mismatch && !i_logic_self_test_done) ##1 i_in_diag |-> o_safe_req)
    else $error("nvm error in diagnostic did not request safe state");
  AST_ILIM_LIVE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    xcv_en_r |=> fault_r[B_XCV_ILIM] == $past(i_xcv_ilim))
    else $error("transceiver current limit flag not live");
  AST_IO_ILIM: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> fault_r[B_IO_ILIM] == $past(i_io_ilim))
    else $error("io current limit flag not live");
  AST_SNS_LIVE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> fault_r[B_SNS_UV] == $past(i_sns_uv) && fault_r[B_SNS_OV] == $past(i_sns_ov))
    else $error("sensor supply voltage flags not live");
  AST_SNS_OFF: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_sns_ot |=> o_sns_reg_disable)
    else $error("sensor regulator not held off on overtemp");
  AST_IO_OFF: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_io_ot |=> o_io_reg_disable)
    else $error("io regulator not held off on overtemp");
  AST_XCV_OT_LIVE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> fault_r[B_XCV_OT] == $past(i_xcv_ot))
    else $error("transceiver overtemp flag not live");
  AST_LOGIC_SELF_TEST: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_logic_self_test_done |=> !cfg_err_r && !nvm_err_r && wd_cnt == WD_CNT_INIT)
    else $error("crc and watchdog status not reinitialised by self-test");
  AST_NVM_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_nvm_crc_done && i_nvm_crc_mismatch && !i_logic_self_test_done) |=> nvm_err_r)
    else $error("nvm crc mismatch not flagged");
  AST_CFG_CLR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cfg_crc_valid && i_cfg_crc_calc == i_cfg_crc_expect) |=> !cfg_err_r)
    else $error("config crc match did not clear error");
endmodule

// ===== dv/sssb_host_model.sv
// host side model: selects one status register and captures the read word
// assumes the bank answers on the edge after the select changes
`timescale 1ns/100ps
module sssb_host_model (
  input  wire logic [sssb_pkg::REG_W-1:0] i_rd_data,
  input  wire logic                       i_sys_clk,
  output logic      [sssb_pkg::SEL_W-1:0] o_rd_sel
);
  import sssb_pkg::*;

  initial begin
    o_rd_sel = SEL_RAIL;
  end

  // select at an edge, let the flag and read registers settle, then capture
  task automatic read(input logic [SEL_W-1:0] sel, output logic [REG_W-1:0] data);
    @(posedge i_sys_clk);
    o_rd_sel <= sel;
    repeat (2) @(posedge i_sys_clk);
    #1;
    data = i_rd_data;
  endtask
endmodule

// ===== dv/sssb_status_bank_test.sv
// self-checking bench for the supply safety status bank
// assumes the host model in the same folder and the design package
`timescale 1ns/100ps
module sssb_status_bank_test;
  import sssb_pkg::*;
  localparam logic [8:0] EV_LOGIC_SELF_TEST = 9'h001, EV_CFG = 9'h002, EV_NVM = 9'h004;
  localparam logic [8:0] EV_DIAG = 9'h008, EV_BAD = 9'h010, EV_GOOD = 9'h020;
  localparam logic [8:0] EV_SET = 9'h040, EV_CLR = 9'h080, EV_MASK = 9'h100;
  logic             i_sys_clk, i_rst, nvm_mis, in_diag, rst_en, mask_val, enable_drive_output_req;
  logic [7:0]       rail, calc, expect_crc, o_rd_data, d;
  logic [6:0]       flt;
  logic [8:0]       ev;
  logic [SEL_W-1:0] rd_sel;
  logic             o_xcv_en, o_xcv_reg_disable, o_sns_reg_disable, o_io_reg_disable;
  logic             o_reset_req, o_safe_req, o_enable_drive_output, o_watchdog_failure_flag;
  logic [31:0]      r;
  int               n_errors, compares, cycles, cnt, cfg, nvm, prev;

  sssb_status_bank sssb_status_bank_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_logic_self_test_done(ev[0]),
    .i_prereg_ov(rail[7]), .i_prereg_uv(rail[6]), .i_xcv_ov(rail[5]), .i_xcv_uv(rail[4]),
    .i_io_ov(rail[3]), .i_io_uv(rail[2]), .i_core_ov(rail[1]), .i_core_uv(rail[0]),
    .i_xcv_ilim(flt[6]), .i_io_ilim(flt[5]), .i_sns_uv(flt[4]), .i_sns_ov(flt[3]),
    .i_sns_ot(flt[2]), .i_xcv_ot(flt[1]), .i_io_ot(flt[0]),
    .i_cfg_crc_valid(ev[1]), .i_cfg_crc_calc(calc), .i_cfg_crc_expect(expect_crc),
    .i_nvm_crc_done(ev[2]), .i_nvm_crc_mismatch(nvm_mis), .i_in_diag(in_diag),
    .i_enter_diag_active(ev[3]), .i_wd_bad(ev[4]), .i_wd_good(ev[5]),
    .i_watchdog_reset_enable(rst_en), .i_xcv_en_set(ev[6]), .i_xcv_en_clr(ev[7]),
    .i_ot_mask_wr(ev[8]), .i_ot_mask_val(mask_val), .i_enable_drive_output_req(enable_drive_output_req),
    .i_rd_sel(rd_sel), .o_rd_data(o_rd_data), .o_xcv_en(o_xcv_en),
    .o_xcv_reg_disable(o_xcv_reg_disable), .o_sns_reg_disable(o_sns_reg_disable),
    .o_io_reg_disable(o_io_reg_disable), .o_reset_req(o_reset_req),
    .o_safe_req(o_safe_req), .o_enable_drive_output(o_enable_drive_output), .o_watchdog_failure_flag(o_watchdog_failure_flag));

  sssb_host_model sssb_host_model_i (
    .i_rd_data(o_rd_data), .i_sys_clk(i_sys_clk), .o_rd_sel(rd_sel));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [SEL_W-1:0] sel, input logic [7:0] exp);
    sssb_host_model_i.read(sel, d);
    chk(d, exp);
  endtask

  // one-cycle event pulse, inputs change only at rising edges
  task automatic fire(input logic [8:0] m);
    @(posedge i_sys_clk);
    ev <= m;
    @(posedge i_sys_clk);
    ev <= 9'h000;
  endtask

  function automatic logic [7:0] crcwd_exp();
    return 8'((cfg << 5) | (nvm << 4) | cnt);
  endfunction

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    i_rst = 1'b1;
    rail = 8'h00;
    flt = 7'h00;
    ev = 9'h000;
    calc = 8'h00;
    expect_crc = 8'h00;
    nvm_mis = 1'b0;
    in_diag = 1'b0;
    rst_en = 1'b0;
    mask_val = 1'b1;
    enable_drive_output_req = 1'b0;
    r = 32'ha2d7;
    cnt = 5;
    cfg = 0;
    nvm = 0;
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rdchk(SEL_RAIL, 8'h00);
    rdchk(SEL_FAULT, 8'h80);
    rdchk(SEL_CRCWD, crcwd_exp());
    rdchk(2'h3, 8'h00);
    chk({7'h0, o_xcv_reg_disable}, 8'h01);
    fire(EV_SET);
    repeat (2) @(posedge i_sys_clk);
    flt <= 7'h02;
    #1;
    chk({7'h0, o_reset_req}, 8'h01);
    rdchk(SEL_FAULT, 8'h82);
    chk({7'h0, o_xcv_en}, 8'h00);
    @(posedge i_sys_clk);
    flt <= 7'h00;
    mask_val <= 1'b0;
    fire(EV_MASK);
    fire(EV_SET);
    for (int i = 0; i < 16; i++) begin
      r = lfsr_next(r);
      @(posedge i_sys_clk);
      rail <= r[7:0];
      flt <= r[14:8];
      rdchk(SEL_RAIL, r[7:0]);
      rdchk(SEL_FAULT, {r[14:11], 1'b0, r[10:8]});
      chk({7'h0, o_sns_reg_disable}, {7'h0, r[10]});
      chk({7'h0, o_io_reg_disable}, {7'h0, r[8]});
      chk({7'h0, o_xcv_en}, 8'h01);
      chk({7'h0, o_xcv_reg_disable}, 8'h00);
      chk({7'h0, o_reset_req}, 8'h00);
    end
    @(posedge i_sys_clk);
    rail <= 8'h00;
    flt <= 7'h00;
    fire(EV_CLR);
    rdchk(SEL_FAULT, 8'h80);
    r = lfsr_next(r);
    @(posedge i_sys_clk);
    calc <= r[7:0];
    expect_crc <= r[7:0] ^ 8'h01;
    fire(EV_CFG);
    cfg = 1;
    rdchk(SEL_CRCWD, crcwd_exp());
    @(posedge i_sys_clk);
    expect_crc <= r[7:0];
    fire(EV_CFG);
    cfg = 0;
    rdchk(SEL_CRCWD, crcwd_exp());
    @(posedge i_sys_clk);
    expect_crc <= r[7:0] ^ 8'h80;
    fire(EV_CFG);
    fire(EV_NVM);
    rdchk(SEL_CRCWD, crcwd_exp());
    @(posedge i_sys_clk);
    nvm_mis <= 1'b1;
    in_diag <= 1'b1;
    fire(EV_CFG | EV_NVM);
    cfg = 1;
    nvm = 1;
    rdchk(SEL_CRCWD, crcwd_exp());
    chk({7'h0, o_safe_req}, 8'h01);
    @(posedge i_sys_clk);
    enable_drive_output_req <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      fire(EV_GOOD);
      cnt = (cnt > 0) ? cnt - 1 : 0;
      rdchk(SEL_CRCWD, crcwd_exp());
    end
    chk({7'h0, o_enable_drive_output}, 8'h01);
    @(posedge i_sys_clk);
    rst_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      prev = cnt;
      fire(EV_BAD);
      cnt = (cnt < 7) ? cnt + 1 : 7;
      #1;
      chk({7'h0, o_watchdog_failure_flag}, {7'h0, prev == 7});
      rdchk(SEL_CRCWD, crcwd_exp());
    end
    chk({7'h0, o_enable_drive_output}, 8'h00);
    // bad event at seven without reset enable: no failure, no wrap
    @(posedge i_sys_clk);
    rst_en <= 1'b0;
    fire(EV_BAD);
    #1;
    chk({7'h0, o_watchdog_failure_flag}, 8'h00);
    rdchk(SEL_CRCWD, crcwd_exp());
    fire(EV_DIAG);
    cnt = 5;
    rdchk(SEL_CRCWD, crcwd_exp());
    // move the counter off five so the self-test reload is visible
    fire(EV_BAD);
    cnt = 6;
    rdchk(SEL_CRCWD, crcwd_exp());
    @(posedge i_sys_clk);
    rail <= 8'h0c;
    fire(EV_LOGIC_SELF_TEST);
    cnt = 5;
    cfg = 0;
    nvm = 0;
    rdchk(SEL_CRCWD, crcwd_exp());
    rdchk(SEL_RAIL, 8'h0c);
    chk({7'h0, o_safe_req}, 8'h00);
    conclude();
  end
endmodule
